/* rtl/port_a_io.sv */
// eight-pin general purpose io port with an axi4-lite register slave
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module port_a_io
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address channel
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response channel
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address channel
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data channel
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pads
  input  wire logic [7:0]  gp_pin_i,
  output wire logic [7:0]  gp_pin_o,
  output wire logic [7:0]  gp_pin_oe,
  output wire logic [7:0]  pull_up_en,
  output wire logic [7:0]  pull_dn_en
);

  // ==========================================================
  // registers
  logic [7:0]  level_q;          // stored output levels
  logic [7:0]  direction_q;      // 0 output, 1 input per pin
  logic [7:0]  sel_low_q;        // low bit of each pin's state code
  logic [7:0]  sel_high_q;       // high bit of each pin's state code
  wire  [7:0]  in_sync;          // synchronised pin levels, one driver per bit

  // ==========================================================
  // write channel state
  logic        aw_held_q;        // write address taken, waiting for data
  logic [29:0] aw_idx_q;         // word index of the held address
  logic        w_held_q;         // write data taken, waiting for address
  logic [31:0] wdata_q;          // held write data
  logic [3:0]  wstrb_q;          // held byte strobes
  logic        bvalid_q;         // write response pending
  logic [1:0]  bresp_q;          // write response code

  // ==========================================================
  // read channel state
  logic        rvalid_q;         // read data pending
  logic [31:0] rdata_q;          // read data
  logic [1:0]  rresp_q;          // read response code

  // ==========================================================
  // write path decode
  // address and data are accepted independently; no new ones while a
  // response waits, so at most one write is in flight
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;

  wire        aw_hs   = s_axi_awvalid & s_axi_awready;
  wire        w_hs    = s_axi_wvalid & s_axi_wready;
  wire        aw_have = aw_held_q | aw_hs;
  wire        w_have  = w_held_q | w_hs;
  wire        do_wr   = aw_have & w_have;                     // both halves present
  wire [29:0] wr_idx  = aw_held_q ? aw_idx_q : s_axi_awaddr[31:2];
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0]  wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;

  wire wr_level = (wr_idx == port_a_pkg::IDX_PIN_LEVEL);
  wire wr_dir   = (wr_idx == port_a_pkg::IDX_PIN_DIRECTION);
  wire wr_sel_w = (wr_idx == port_a_pkg::IDX_STATE_SEL_LOW);
  wire wr_sel_h = (wr_idx == port_a_pkg::IDX_STATE_SEL_HIGH);
  wire wr_hit   = wr_level | wr_dir | wr_sel_w | wr_sel_h;

  wire [7:0] wr_byte0 = wr_data[port_a_pkg::FLD_BYTE0_LSB +: 8];
  wire [7:0] wr_byte1 = wr_data[port_a_pkg::FLD_BYTE1_LSB +: 8];

  // byte lane 0 feeds each 8-bit register; the word form of the
  // selector pair puts the high selector in lane 1
  wire we_level  = do_wr & wr_level & wr_strb[0];
  wire we_dir    = do_wr & wr_dir & wr_strb[0];
  wire we_sel_lo = do_wr & wr_sel_w & wr_strb[0];
  wire we_sel_hi = do_wr & ((wr_sel_w & wr_strb[1]) | (wr_sel_h & wr_strb[0]));

  // ==========================================================
  // write channel holding registers and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_idx_q  <= 30'h00000000;
      w_held_q  <= 1'b0;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= port_a_pkg::RESP_OKAY;
    end
    else
    begin
      // address arrives before data: keep it
      if (aw_hs && !do_wr)
      begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[31:2];
      end
      // data arrives before address: keep it
      if (w_hs && !do_wr)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      // both present: write completes, response raised
      if (do_wr)
      begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? port_a_pkg::RESP_OKAY : port_a_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ==========================================================
  // port registers
  // every register clears to zero, leaving all pins hiz outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_q     <= port_a_pkg::RST_PIN_LEVEL;
      direction_q <= port_a_pkg::RST_PIN_DIRECTION;
      sel_low_q   <= port_a_pkg::RST_STATE_SEL_LOW;
      sel_high_q  <= port_a_pkg::RST_STATE_SEL_HIGH;
    end
    else
    begin
      // level keeps what software writes, whatever the direction
      if (we_level)
      begin
        level_q <= wr_byte0;
      end
      if (we_dir)
      begin
        direction_q <= wr_byte0;
      end
      if (we_sel_lo)
      begin
        sel_low_q <= wr_byte0;
      end
      // lane 1 only in the word form at the low selector address
      if (we_sel_hi)
      begin
        sel_high_q <= wr_sel_w ? wr_byte1 : wr_byte0;
      end
    end
  end

  // ==========================================================
  // read path decode
  assign s_axi_arready = ~rvalid_q;

  wire        ar_hs    = s_axi_arvalid & s_axi_arready;
  wire [29:0] rd_idx   = s_axi_araddr[31:2];
  wire        rd_level = (rd_idx == port_a_pkg::IDX_PIN_LEVEL);
  wire        rd_dir   = (rd_idx == port_a_pkg::IDX_PIN_DIRECTION);
  wire        rd_sel_w = (rd_idx == port_a_pkg::IDX_STATE_SEL_LOW);
  wire        rd_sel_h = (rd_idx == port_a_pkg::IDX_STATE_SEL_HIGH);
  wire        rd_hit   = rd_level | rd_dir | rd_sel_w | rd_sel_h;

  // inputs show the pin, outputs show the stored level
  wire [7:0]  level_view = (direction_q & in_sync) | (~direction_q & level_q);

  wire [31:0] rd_word =
      rd_level ? {24'h000000, level_view} :
      rd_dir   ? {24'h000000, direction_q} :
      rd_sel_w ? {16'h0000, sel_high_q, sel_low_q} :
      rd_sel_h ? {24'h000000, sel_high_q} :
                 32'h00000000;

  // ==========================================================
  // read data register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= port_a_pkg::RESP_OKAY;
    end
    else if (ar_hs)
    begin
      // unmapped reads return zero with slave error
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? port_a_pkg::RESP_OKAY : port_a_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ==========================================================
  // one pad controller per pin, bit n configures pin n
  for (genvar n = 0; n < port_a_pkg::PIN_COUNT; n++)
  begin : g_pin
    pad_cfg_if cfg ();

    assign cfg.dir    = direction_q[n];
    assign cfg.sel    = {sel_high_q[n], sel_low_q[n]};
    assign cfg.level  = level_q[n];
    assign cfg.pin_in = gp_pin_i[n];
    assign gp_pin_o[n]   = cfg.pin_out;
    assign gp_pin_oe[n]  = cfg.pin_oe;
    assign pull_up_en[n] = cfg.pull_up;
    assign pull_dn_en[n] = cfg.pull_dn;
    assign in_sync[n]    = cfg.in_sync;

    pad_ctl u_pad
    (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cfg     (cfg.pad)
    );
  end

endmodule

/* rtl/port_a_pkg.sv */
// constants, register map and field layout of the eight-pin io port
// Operation
// - eight pins, each set by bit n
// - output mode drives level register bit
// - level register reads back written value on output pins
// - input pins read synchronised pin level
// - direction bit 0 output, 1 input
// - selector high/low bits form pin code
// - output codes: hiz, p-drain, n-drain, push-pull
// - input codes: hiz, pull-down, pull-up, hiz
// - reset clears all registers to zero
// - selectors reachable as bytes or word
package port_a_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned PIN_COUNT = 8;            // pins in the port
  localparam int unsigned ADDR_W    = 32;           // bus address width
  localparam int unsigned DATA_W    = 32;           // bus data width

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [29:0] IDX_PIN_LEVEL       = 30'h0000f250;
  localparam logic [29:0] IDX_PIN_DIRECTION   = 30'h0000f251;
  localparam logic [29:0] IDX_STATE_SEL_LOW   = 30'h0000f252;
  localparam logic [29:0] IDX_STATE_SEL_HIGH  = 30'h0000f253;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_PIN_LEVEL      = 8'h00;
  localparam logic [7:0] RST_PIN_DIRECTION  = 8'h00;
  localparam logic [7:0] RST_STATE_SEL_LOW  = 8'h00;
  localparam logic [7:0] RST_STATE_SEL_HIGH = 8'h00;

  // ==========================================================
  // field positions inside the bus word
  localparam int unsigned FLD_BYTE0_LSB = 0;       // 8-bit registers
  localparam int unsigned FLD_BYTE1_LSB = 8;       // high selector in word access

  // ==========================================================
  // direction encoding
  localparam logic DIR_OUTPUT = 1'b0;
  localparam logic DIR_INPUT  = 1'b1;

  // ==========================================================
  // pin state selector codes {high, low}
  localparam logic [1:0] SEL_HIZ      = 2'h0;      // out: hiz, in: hiz
  localparam logic [1:0] SEL_P_DRAIN  = 2'h1;      // out: p-drain, in: pull-down
  localparam logic [1:0] SEL_N_DRAIN  = 2'h2;      // out: n-drain, in: pull-up
  localparam logic [1:0] SEL_PUSHPULL = 2'h3;      // out: push-pull, in: hiz

  // ==========================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* rtl/pad_cfg_if.sv */
// per-pin carrier between the register block and one pad controller
`timescale 1ns/1ns
interface pad_cfg_if;
  logic       dir;        // direction bit of this pin
  logic [1:0] sel;        // state selector code {high, low}
  logic       level;      // stored output level
  logic       pin_in;     // raw pin level from the pad
  logic       pin_out;    // value driven on the pad
  logic       pin_oe;     // pad driver enable, high while driving
  logic       pull_up;    // pull-up resistor enable
  logic       pull_dn;    // pull-down resistor enable
  logic       in_sync;    // synchronised pin level

  // register block side
  modport regs (output dir, output sel, output level, output pin_in,
                input pin_out, input pin_oe, input pull_up, input pull_dn, input in_sync);
  // pad controller side
  modport pad  (input dir, input sel, input level, input pin_in,
                output pin_out, output pin_oe, output pull_up, output pull_dn,
                output in_sync);
endinterface

/* rtl/pad_ctl.sv */
// pad controller for one pin: drive decode, pulls and input synchroniser
`timescale 1ns/1ns
module pad_ctl
(
  input  wire logic aclk,
  input  wire logic aresetn,
  pad_cfg_if.pad    cfg
);

  // ==========================================================
  // input synchroniser
  logic meta_q;           // first stage, read only by the second
  logic sync_q;           // second stage

  // two flops on the system clock before anything reads the pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= cfg.pin_in;
      sync_q <= meta_q;
    end
  end

  assign cfg.in_sync = sync_q;

  // ==========================================================
  // drive decode
  wire is_out   = (cfg.dir == port_a_pkg::DIR_OUTPUT);
  wire code_pp  = (cfg.sel == port_a_pkg::SEL_PUSHPULL);
  wire code_pd  = (cfg.sel == port_a_pkg::SEL_P_DRAIN);
  wire code_nd  = (cfg.sel == port_a_pkg::SEL_N_DRAIN);

  // push-pull drives both levels, p-drain only high, n-drain only low
  wire drive_pp = is_out & code_pp;
  wire drive_hi = is_out & code_pd & cfg.level;
  wire drive_lo = is_out & code_nd & ~cfg.level;

  assign cfg.pin_oe  = drive_pp | drive_hi | drive_lo;
  assign cfg.pin_out = cfg.level;
  // pulls act only in input mode; codes 00 and 11 stay high impedance
  assign cfg.pull_dn = ~is_out & code_pd;
  assign cfg.pull_up = ~is_out & code_nd;

endmodule

/* verif/port_a_io_asserts.sv */
// concurrent checks on the port's bus channels and pad outputs
`timescale 1ns/1ns
module port_a_io_asserts
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  gp_pin_o,
  input wire logic [7:0]  gp_pin_oe,
  input wire logic [7:0]  pull_up_en,
  input wire logic [7:0]  pull_dn_en
);
  // ==========================================================
  // decode of a write whose two halves are taken at one edge
  wire        wr_go  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire [29:0] aw_idx = s_axi_awaddr[31:2];  // word index of the write
  wire        lvl_w  = aw_idx == port_a_pkg::IDX_PIN_LEVEL;
  wire        map_w  = aw_idx >= port_a_pkg::IDX_PIN_LEVEL
                       && aw_idx <= port_a_pkg::IDX_STATE_SEL_HIGH;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // reset and pad drive
  reset_clear_a: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && gp_pin_oe == 8'h00
    && pull_up_en == 8'h00 && pull_dn_en == 8'h00) else $error("reset left outputs set");
  level_drive_a: assert property (
    wr_go && lvl_w && s_axi_wstrb[0] |=> gp_pin_o == $past(s_axi_wdata[7:0]))
    else $error("pad value differs from written level");
  pull_excl_a: assert property (
    (pull_up_en & pull_dn_en) == 8'h00 && ((pull_up_en | pull_dn_en) & gp_pin_oe) == 8'h00)
    else $error("pull enables clash");

  // ==========================================================
  // bus answers and holding
  wr_answer_a: assert property (wr_go |=> s_axi_bvalid)
    else $error("write response late");
  unmapped_err_a: assert property (wr_go && !map_w |=> s_axi_bresp == port_a_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  busy_refuse_a: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    and (s_axi_rvalid |-> !s_axi_arready)) else $error("request taken while busy");
endmodule

bind port_a_io port_a_io_asserts port_a_io_asserts_i (.*);

/* verif/pad_model.sv */
// external circuit on the eight pads: resolves each wire level
`timescale 1ns/1ns
module pad_model
(
  input  wire logic       aclk,
  input  wire logic [7:0] drv_o,   // device pad value
  input  wire logic [7:0] drv_oe,  // device drives the pad
  input  wire logic [7:0] pu,      // pull-up on
  input  wire logic [7:0] pd,      // pull-down on
  input  wire logic [7:0] ext_v,   // outside driver value
  input  wire logic [7:0] ext_oe,  // outside driver on
  output logic      [7:0] pin      // resolved wire level
);
  logic [7:0] float_q;  // a floating wire wanders every cycle

  // ==========================================================
  // floating pattern, so an undriven pad never looks stable
  always_ff @(posedge aclk)
    float_q <= (float_q === 8'hxx) ? 8'h55 : ~float_q;

  // device first, then outside driver, then pulls, else floating
  assign pin = drv_oe & drv_o | ~drv_oe & (ext_oe & ext_v | ~ext_oe & (pu | ~pd & float_q));
endmodule

/* verif/tb_top.sv */
// self-checking bench for the eight-pin io port over axi4-lite
`timescale 1ns/1ns
module tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot = 3'h0;  // protection unused by the port
  logic [2:0]  s_axi_arprot = 3'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  gp_pin_i, gp_pin_o, gp_pin_oe, pull_up_en, pull_dn_en, ext_v, ext_oe;
  logic [7:0]  lv, dr, c0, c1, e_v, e_oe;  // shadow registers and outside drive
  logic [31:0] w, pe;
  logic [1:0]  qb[$];                      // expected write responses
  logic [33:0] qr[$];                      // expected {rresp, rdata}
  int          n_errors, n_tests, seed;

  port_a_io port_a_io_i (.*);
  pad_model pad_model_i (.aclk(aclk), .drv_o(gp_pin_o), .drv_oe(gp_pin_oe), .pu(pull_up_en),
                         .pd(pull_dn_en), .ext_v(ext_v), .ext_oe(ext_oe), .pin(gp_pin_i));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==========================================================
  // comparison, verdict and helpers
  task automatic check(string nm, logic [33:0] seen, logic [33:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] adr(int i);  // byte address of register index i
    return {port_a_pkg::IDX_PIN_LEVEL + 30'(i), 2'b00};
  endfunction

  // expected {oe, pull up, pull down, pad value} from the four registers
  function automatic logic [31:0] pins_f(logic [7:0] l, d, a, b);
    return {~d & (a & b | a & ~b & l | ~a & b & ~l), d & b & ~a, d & a & ~b, l};
  endfunction

  // one axi4-lite transfer, write or read; e is the expected answer
  task automatic bus(bit rd, int i, logic [31:0] d, logic [3:0] s, logic [33:0] e);
    bit ta, tw, tb;
    if (rd) qr.push_back(e);
    else qb.push_back(e[33:32]);
    @(posedge aclk);
    if (rd)
    begin
      s_axi_araddr <= adr(i); s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    end
    else
    begin
      s_axi_awaddr <= adr(i); s_axi_wdata <= d; s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    end
    // wait as long as the slave needs; only the watchdog ends a hang
    forever
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (ta)
      begin
        s_axi_awvalid <= 1'b0; s_axi_arvalid <= 1'b0;
      end
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb)
      begin
        s_axi_bready <= 1'b0; s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // ==========================================================
  // monitor takes the oldest note whenever an answer is handed over
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready) check("bresp", 34'(s_axi_bresp), 34'(qb.pop_front()));
    if (s_axi_rvalid && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata}, qr.pop_front());
  end

  // watchdog: the tests need under a thousand cycles
  initial
  begin
    #100000;
    n_errors++;
    report_and_stop;
  end

  // ==========================================================
  // main sequence
  initial
  begin
    aresetn = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = 32'h0; s_axi_araddr = 32'h0;
    s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0; ext_v = 8'h00; ext_oe = 8'h00;
    n_errors = 0; n_tests = 0; lv = 8'h00; dr = 8'h00; c0 = 8'h00; c1 = 8'h00;
    seed = $urandom(32'h0438);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, then an unmapped address both ways
    for (int i = 0; i < 4; i++) bus(1, i, 32'h0, 4'h0, 34'h0);
    check("pads", 34'({gp_pin_oe, pull_up_en, pull_dn_en, gp_pin_o}), 34'(32'h0));
    bus(1, 4, 32'h0, 4'h0, {port_a_pkg::RESP_SLVERR, 32'h0});
    bus(0, 4, 32'hffffffff, 4'hf, {port_a_pkg::RESP_SLVERR, 32'h0});
    $display("test reset done");
    // random modes: 24 rounds of random codes and directions on every pin
    repeat (24)
    begin
      w = $urandom;
      bus(0, 0, w, 4'h1, 34'h0);
      lv = w[7:0];
      w = $urandom;
      bus(0, 1, w, 4'h1, 34'h0);
      dr = w[7:0];
      w = $urandom;
      bus(0, 2, w, w[27:24], 34'h0);
      if (w[24]) c0 = w[7:0];
      if (w[25]) c1 = w[15:8];
      if (w[26])
      begin
        bus(0, 3, w, 4'h1, 34'h0);
        c1 = w[7:0];
      end
      pe = pins_f(lv, dr, c0, c1);
      e_v = 8'($urandom);
      e_oe = dr & (8'($urandom) | ~(pe[23:16] | pe[15:8]));
      ext_v <= e_v;
      ext_oe <= e_oe;
      repeat (3) @(posedge aclk);
      check("pads", 34'({gp_pin_oe, pull_up_en, pull_dn_en, gp_pin_o}), 34'(pe));
      bus(1, 0, 32'h0, 4'h0, {26'h0, lv & ~dr | dr & (e_oe & e_v | ~e_oe & pe[23:16])});
      bus(1, 1, 32'h0, 4'h0, {26'h0, dr});
      bus(1, 2, 32'h0, 4'h0, {18'h0, c1, c0});
      bus(1, 3, 32'h0, 4'h0, {26'h0, c1});
    end
    $display("test modes done");
    // input change reaches a read only after two synchroniser stages
    bus(0, 1, 32'hff, 4'h1, 34'h0);
    ext_oe <= 8'hff;
    ext_v <= 8'h00;
    repeat (4) @(posedge aclk);
    ext_v <= 8'h5a;
    bus(1, 0, 32'h0, 4'h0, 34'h0);
    bus(1, 0, 32'h0, 4'h0, 34'h5a);
    $display("test sync done");
    report_and_stop;
  end
endmodule
